// file: cct_pkg.sv
// Constants for the two-channel capture/compare timer.
// Assumes a 32-bit APB slave with byte addresses in the low eight bits.
package cct_pkg;

    // ==========================================================
    // Register byte offsets.
    localparam logic [7:0] OFS_COUNTER = 8'h00;
    localparam logic [7:0] OFS_CTRL = 8'h04;
    localparam logic [7:0] OFS_EDGE = 8'h08;
    localparam logic [7:0] OFS_CH0_CTL = 8'h0C;
    localparam logic [7:0] OFS_CH1_CTL = 8'h10;
    localparam logic [7:0] OFS_MATCH0 = 8'h14;
    localparam logic [7:0] OFS_MATCH1 = 8'h18;
    localparam logic [7:0] OFS_RELOAD0 = 8'h1C;
    localparam logic [7:0] OFS_RELOAD1 = 8'h20;
    localparam logic [7:0] OFS_REQUEST = 8'h24;
    localparam logic [7:0] OFS_ENABLE = 8'h28;
    localparam logic [7:0] OFS_PRIORITY = 8'h2C;

    // ==========================================================
    // Field positions.
    localparam int RUN_BIT = 3;
    localparam int MODE_BIT0 = 4;
    localparam int EDGE_LSB0 = 2;
    localparam int LVL_PIN = 0;
    localparam int LVL_NEXT = 1;
    localparam int LVL_AFTER = 2;
    localparam int REQ_OVF = 0;
    localparam int REQ_CH0 = 1;

    // ==========================================================
    // Reset and fixed read values, and the counter maximum.
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] EDGE_RST = 8'hC0;
    localparam logic [7:0] CHCTL_RST = 8'hF8;
    localparam logic [15:0] CNT_MAX = 16'hFFFF;

    // ==========================================================
    // Capture edge encodings.
    localparam logic [1:0] EDGE_NONE = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    // ==========================================================
    // Priority levels.
    localparam logic [1:0] PRIO_TOP = 2'h2;

endpackage

// file: cct_timer.sv
// Two-channel capture/compare timer on a 16-bit free running counter.
// Assumes an APB master on CORE_CLK, a one-cycle time base tick and an
// instruction start strobe, both from logic on CORE_CLK.
// Function
// - Capture edge while running copies counter to match and raises request.
// - Capture pins are sampled on the falling clock edge.
// - Compare channels compare match to counter on each time base tick while running.
// - On match, next level moves into the pin level bit.
// - On match, after-next level moves into the next level bit.
// - On match, reload register value loads into the match register.
// - Match signal rises one counter interval after counter equals match.
// - Pin changes as the match signal and counter tick end together.
// - With undivided ticks the pin changes as counter moves from match plus one to match plus two.
// - Compare request flag sets at the next instruction start strobe.
// - Counter advances only on the time base tick.
// - Overflow, channel 0 and channel 1 each set their own request flag.
// - Each request has its own enable flag.
// - Each request has two priority bits selecting three levels.
// - Mode bits 4 and 5 choose capture when one, compare when zero.
// - Run bit 3 starts and halts the counter.
// - Edge select bits 2-3 serve channel 0, bits 4-5 channel 1.
`timescale 1ns/1ps
`default_nettype none

module cct_timer
(
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic TBC_TICK,
    input wire logic INSN_START,
    input wire logic CH0_PIN_IN,
    input wire logic CH1_PIN_IN,
    output logic CH0_PIN_OUT,
    output logic CH0_PIN_OE_N,
    output logic CH1_PIN_OUT,
    output logic CH1_PIN_OE_N,
    output logic OVF_REQ,
    output logic CH0_REQ,
    output logic CH1_REQ,
    output logic [1:0] OVF_PRIO,
    output logic [1:0] CH0_PRIO,
    output logic [1:0] CH1_PRIO
);

    // ==========================================================
    // State.
    typedef struct packed {
        logic [15:0] cnt;
        logic [2:0] clk_sel;
        logic run;
        logic [1:0] mode;
        logic [1:0][1:0] edge_sel;
        logic [1:0][2:0] lvl;
        logic [1:0][15:0] match;
        logic [1:0][15:0] reload;
        logic [2:0] req;
        logic [2:0] en;
        logic [2:0][1:0] prio;
        logic [1:0] hit;
        logic [1:0] pend;
        logic [1:0] pin_s;
        logic [1:0] pin_p;
        logic [31:0] prdata;
    } cct_state_s;

    cct_state_s s_r;
    cct_state_s s_nxt;
    logic [1:0] smp_neg_r;

    // ==========================================================
    // Helpers.
    function automatic logic edge_hit(input logic [1:0] sel,
                                      input logic prev,
                                      input logic cur);
        logic rise;
        logic fall;
        rise = cur & ~prev;
        fall = prev & ~cur;
        unique case (sel)
            cct_pkg::EDGE_NONE: edge_hit = 1'b0;
            cct_pkg::EDGE_RISE: edge_hit = rise;
            cct_pkg::EDGE_FALL: edge_hit = fall;
            cct_pkg::EDGE_BOTH: edge_hit = rise | fall;
        endcase
    endfunction

    function automatic logic [1:0] prio_level(input logic [1:0] raw);
        prio_level = (raw > cct_pkg::PRIO_TOP) ? cct_pkg::PRIO_TOP : raw;
    endfunction

    function automatic logic [31:0] read_reg(input cct_state_s st,
                                             input logic [7:0] addr);
        read_reg = 32'h0000_0000;
        unique case (addr)
            cct_pkg::OFS_COUNTER: read_reg = {16'h0000, st.cnt};
            cct_pkg::OFS_CTRL: read_reg = {26'h000_0000, st.mode,
                                           st.run, st.clk_sel};
            cct_pkg::OFS_EDGE: read_reg = {24'h00_0000,
                                           cct_pkg::EDGE_RST[7:6],
                                           st.edge_sel, 2'h0};
            cct_pkg::OFS_CH0_CTL: read_reg = {24'h00_0000,
                                              cct_pkg::CHCTL_RST[7:3],
                                              st.lvl[0]};
            cct_pkg::OFS_CH1_CTL: read_reg = {24'h00_0000,
                                              cct_pkg::CHCTL_RST[7:3],
                                              st.lvl[1]};
            cct_pkg::OFS_MATCH0: read_reg = {16'h0000, st.match[0]};
            cct_pkg::OFS_MATCH1: read_reg = {16'h0000, st.match[1]};
            cct_pkg::OFS_RELOAD0: read_reg = {16'h0000, st.reload[0]};
            cct_pkg::OFS_RELOAD1: read_reg = {16'h0000, st.reload[1]};
            cct_pkg::OFS_REQUEST: read_reg = {29'h0000_0000, st.req};
            cct_pkg::OFS_ENABLE: read_reg = {29'h0000_0000, st.en};
            cct_pkg::OFS_PRIORITY: read_reg = {26'h000_0000, st.prio};
            default: read_reg = 32'h0000_0000;
        endcase
    endfunction

    function automatic logic mapped(input logic [7:0] addr);
        mapped = (addr <= cct_pkg::OFS_PRIORITY) && (addr[1:0] == 2'h0);
    endfunction

    // ==========================================================
    // Bus decode.
    logic wr_acc;
    logic rd_setup;
    logic tick;
    logic [2:0] req_set;
    logic [1:0] cmp_fire;

    assign wr_acc = PSEL & PENABLE & PWRITE & mapped(PADDR);
    assign rd_setup = PSEL & ~PENABLE & ~PWRITE;
    assign tick = s_r.run & TBC_TICK;

    // ==========================================================
    // Next state.
    always_comb
    begin
        s_nxt = s_r;
        req_set = 3'h0;
        cmp_fire = 2'h0;

        if (rd_setup)
        begin
            s_nxt.prdata = read_reg(s_r, PADDR);
        end

        if (wr_acc)
        begin
            unique case (PADDR)
                cct_pkg::OFS_COUNTER: s_nxt.cnt = PWDATA[15:0];
                cct_pkg::OFS_CTRL:
                begin
                    s_nxt.clk_sel = PWDATA[2:0];
                    s_nxt.run = PWDATA[cct_pkg::RUN_BIT];
                    s_nxt.mode = PWDATA[cct_pkg::MODE_BIT0 +: 2];
                end
                cct_pkg::OFS_EDGE:
                    s_nxt.edge_sel = PWDATA[cct_pkg::EDGE_LSB0 +: 4];
                cct_pkg::OFS_CH0_CTL: s_nxt.lvl[0] = PWDATA[2:0];
                cct_pkg::OFS_CH1_CTL: s_nxt.lvl[1] = PWDATA[2:0];
                cct_pkg::OFS_MATCH0: s_nxt.match[0] = PWDATA[15:0];
                cct_pkg::OFS_MATCH1: s_nxt.match[1] = PWDATA[15:0];
                cct_pkg::OFS_RELOAD0: s_nxt.reload[0] = PWDATA[15:0];
                cct_pkg::OFS_RELOAD1: s_nxt.reload[1] = PWDATA[15:0];
                cct_pkg::OFS_REQUEST: s_nxt.req = PWDATA[2:0];
                cct_pkg::OFS_ENABLE: s_nxt.en = PWDATA[2:0];
                cct_pkg::OFS_PRIORITY: s_nxt.prio = PWDATA[5:0];
                default: s_nxt.req = s_r.req;
            endcase
        end

        // Counter step; a software write in the same cycle wins.
        if (tick && !(wr_acc && PADDR == cct_pkg::OFS_COUNTER))
        begin
            s_nxt.cnt = s_r.cnt + 16'h0001;
        end
        if (tick && s_r.cnt == cct_pkg::CNT_MAX)
        begin
            req_set[cct_pkg::REQ_OVF] = 1'b1;
        end

        s_nxt.pin_s = smp_neg_r;
        s_nxt.pin_p = s_r.pin_s;

        for (int ch = 0; ch < 2; ch++)
        begin
            if (s_r.mode[ch])
            begin
                if (s_r.run && edge_hit(s_r.edge_sel[ch], s_r.pin_p[ch],
                                        s_r.pin_s[ch]))
                begin
                    s_nxt.match[ch] = s_r.cnt;
                    req_set[cct_pkg::REQ_CH0 + ch] = 1'b1;
                end
                s_nxt.hit[ch] = 1'b0;
                s_nxt.pend[ch] = 1'b0;
            end
            else
            begin
                // pin change at end of tick with match signal high
                if (tick && s_r.hit[ch])
                begin
                    cmp_fire[ch] = 1'b1;
                    s_nxt.hit[ch] = 1'b0;
                    s_nxt.lvl[ch][cct_pkg::LVL_PIN] =
                        s_r.lvl[ch][cct_pkg::LVL_NEXT];
                    s_nxt.lvl[ch][cct_pkg::LVL_NEXT] =
                        s_r.lvl[ch][cct_pkg::LVL_AFTER];
                    s_nxt.match[ch] = s_r.reload[ch];
                end
                if (tick && s_r.cnt == s_r.match[ch])
                begin
                    s_nxt.hit[ch] = 1'b1;
                end
                if (s_r.pend[ch] && INSN_START)
                begin
                    req_set[cct_pkg::REQ_CH0 + ch] = 1'b1;
                    s_nxt.pend[ch] = 1'b0;
                end
                if (cmp_fire[ch])
                begin
                    s_nxt.pend[ch] = 1'b1;
                end
            end
        end

        s_nxt.req = s_nxt.req | req_set;
    end

    // ==========================================================
    // Registers.
    // falling edge sampler
    always_ff @(negedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            smp_neg_r <= 2'h0;
        end
        else
        begin
            smp_neg_r <= {CH1_PIN_IN, CH0_PIN_IN};
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            s_r <= '0;
            s_r.clk_sel <= cct_pkg::CTRL_RST[2:0];
            s_r.run <= cct_pkg::CTRL_RST[cct_pkg::RUN_BIT];
            s_r.mode <= cct_pkg::CTRL_RST[cct_pkg::MODE_BIT0 +: 2];
            s_r.edge_sel <= cct_pkg::EDGE_RST[cct_pkg::EDGE_LSB0 +: 4];
            s_r.lvl[0] <= cct_pkg::CHCTL_RST[2:0];
            s_r.lvl[1] <= cct_pkg::CHCTL_RST[2:0];
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // ==========================================================
    // Outputs.
    assign PRDATA = s_r.prdata;
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL & PENABLE & ~mapped(PADDR);
    // pin follows the level bit at the change edge
    assign CH0_PIN_OUT = s_r.lvl[0][cct_pkg::LVL_PIN];
    assign CH1_PIN_OUT = s_r.lvl[1][cct_pkg::LVL_PIN];
    assign CH0_PIN_OE_N = s_r.mode[0];
    assign CH1_PIN_OE_N = s_r.mode[1];
    assign OVF_REQ = s_r.req[0] & s_r.en[0];
    assign CH0_REQ = s_r.req[1] & s_r.en[1];
    assign CH1_REQ = s_r.req[2] & s_r.en[2];
    assign OVF_PRIO = prio_level(s_r.prio[0]);
    assign CH0_PRIO = prio_level(s_r.prio[1]);
    assign CH1_PRIO = prio_level(s_r.prio[2]);

endmodule // cct_timer

`default_nettype wire

// file: cct_props.sv
// Checker on the capture/compare timer ports.
// Assumes every port sits on CORE_CLK; bound into cct_timer.
`timescale 1ns/1ps
`default_nettype none
module cct_props
(
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic TBC_TICK,
    input wire logic INSN_START,
    input wire logic CH1_PIN_IN,
    input wire logic CH0_PIN_OUT,
    input wire logic CH0_PIN_OE_N,
    input wire logic CH1_PIN_OE_N,
    input wire logic CH0_REQ,
    input wire logic CH1_REQ,
    input wire logic [1:0] OVF_PRIO,
    input wire logic [1:0] CH0_PRIO,
    input wire logic [1:0] CH1_PRIO
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    logic wr;
    assign wr = PSEL && PENABLE && PWRITE;
    // =========================================
    // Assertions.
    property p_prio_ovf; OVF_PRIO != 2'h3; endproperty
    a_prio_ovf: assert property (p_prio_ovf) else $error("ovf prio");
    property p_prio_ch0; CH0_PRIO != 2'h3; endproperty
    a_prio_ch0: assert property (p_prio_ch0) else $error("ch0 prio");
    property p_prio_ch1; CH1_PRIO != 2'h3; endproperty
    a_prio_ch1: assert property (p_prio_ch1) else $error("ch1 prio");
    property p_mode0; $changed(CH0_PIN_OE_N) |->
        $past(wr) && $past(PADDR) == cct_pkg::OFS_CTRL; endproperty
    a_mode0: assert property (p_mode0) else $error("ch0 mode");
    property p_mode1; $changed(CH1_PIN_OE_N) |->
        $past(wr) && $past(PADDR) == cct_pkg::OFS_CTRL; endproperty
    a_mode1: assert property (p_mode1) else $error("ch1 mode");
    property p_pin0; $changed(CH0_PIN_OUT) && $past(!CH0_PIN_OE_N) |->
        $past(TBC_TICK) || $past(wr); endproperty
    a_pin0: assert property (p_pin0) else $error("ch0 pin");
    property p_req0; $rose(CH0_REQ) && !CH0_PIN_OE_N |->
        $past(INSN_START) || $past(wr); endproperty
    a_req0: assert property (p_req0) else $error("ch0 req");
    property p_cap1; $rose(CH1_REQ) && CH1_PIN_OE_N |->
        $past(CH1_PIN_IN, 2) != $past(CH1_PIN_IN, 5) || $past(wr); endproperty
    a_cap1: assert property (p_cap1) else $error("ch1 capture");
    c_req: cover property ($rose(CH0_REQ));
    c_pin: cover property ($changed(CH0_PIN_OUT));
    c_mode: cover property ($rose(CH1_PIN_OE_N));
endmodule // cct_props
bind cct_timer cct_props u_props
(
    .CORE_CLK(CORE_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .TBC_TICK(TBC_TICK),
    .INSN_START(INSN_START), .CH1_PIN_IN(CH1_PIN_IN),
    .CH0_PIN_OUT(CH0_PIN_OUT), .CH0_PIN_OE_N(CH0_PIN_OE_N),
    .CH1_PIN_OE_N(CH1_PIN_OE_N), .CH0_REQ(CH0_REQ), .CH1_REQ(CH1_REQ),
    .OVF_PRIO(OVF_PRIO), .CH0_PRIO(CH0_PRIO), .CH1_PRIO(CH1_PRIO)
);
`default_nettype wire

// file: cct_pin_model.sv
// Pulse source and load on one channel pin.
// Assumes the design's output enable is low while it drives the pin.
`timescale 1ns/1ps
`default_nettype none
module cct_pin_model
(
    input wire logic clk,
    input wire logic pin_out,
    input wire logic pin_oe_n,
    output logic pin
);
    logic src = 1'h0;
    assign pin = pin_oe_n ? src : pin_out;
    task automatic drive(input logic v);
        @(posedge clk);
        src <= v;
        repeat (6) @(posedge clk);
    endtask
endmodule // cct_pin_model
`default_nettype wire

// file: cct_timer_tb.sv
// Bench for the capture/compare timer over APB with pin models.
// Assumes a 25 MHz clock; ticks and strobes come from the bench.
`timescale 1ns/1ps
`default_nettype none
module cct_timer_tb;
    logic clk = 1'h0, rst = 1'h1, psel = 1'h0, pen = 1'h0, pwr = 1'h0;
    logic tick = 1'h0, insn = 1'h0;
    logic [7:0] pa = 8'h0;
    logic [31:0] pwd = 32'h0, prd, rd;
    logic rdy, perr, err, o0, o1, oe0_n, oe1_n, p0, p1, ovf, r0, r1, hit;
    logic [1:0] po, pc0, pc1;
    int fail_count = 0;
    int checks_done = 0;
    int n;
    cct_timer uut
    (
        .CORE_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(pen),
        .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PRDATA(prd),
        .PREADY(rdy), .PSLVERR(perr), .TBC_TICK(tick), .INSN_START(insn),
        .CH0_PIN_IN(p0), .CH1_PIN_IN(p1), .CH0_PIN_OUT(o0),
        .CH0_PIN_OE_N(oe0_n), .CH1_PIN_OUT(o1), .CH1_PIN_OE_N(oe1_n),
        .OVF_REQ(ovf), .CH0_REQ(r0), .CH1_REQ(r1),
        .OVF_PRIO(po), .CH0_PRIO(pc0), .CH1_PRIO(pc1)
    );
    cct_pin_model src0 (.clk(clk), .pin_out(o0), .pin_oe_n(oe0_n), .pin(p0));
    cct_pin_model src1 (.clk(clk), .pin_out(o1), .pin_oe_n(oe1_n), .pin(p1));
    initial forever #20 clk = ~clk;
    // =========================================
    // Tasks.
    task automatic chk(input string nm, input logic [31:0] e, g);
        checks_done++;
        if (g !== e)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'h1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'h1;
        do @(posedge clk); while (rdy !== 1'h1);
        rd = prd;
        err = perr;
        psel <= 1'h0;
        pen <= 1'h0;
    endtask
    task automatic rdc(input logic [7:0] a, input string nm,
                       input logic [31:0] e);
        apb(1'h0, a, 32'h0);
        chk(nm, e, rd);
    endtask
    task automatic cdiff(input logic [31:0] e);
        logic [31:0] a;
        apb(1'h0, cct_pkg::OFS_COUNTER, 32'h0);
        a = rd;
        rdc(cct_pkg::OFS_COUNTER, "count step", a + e);
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // =========================================
    // Tests.
    initial
    begin
        repeat (20000) @(posedge clk);
        fail_count++;
        give_verdict();
    end
    initial
    begin
        repeat (4) @(posedge clk);
        rst <= 1'h0;
        rdc(cct_pkg::OFS_CTRL, "ctrl", 32'h0);
        rdc(cct_pkg::OFS_EDGE, "edge", 32'hC0);
        rdc(cct_pkg::OFS_CH1_CTL, "ctl1", 32'hF8);
        rdc(8'h30, "unmapped", 32'h0);
        chk("slverr", 32'h1, 32'(err));
        apb(1'h1, cct_pkg::OFS_PRIORITY, 32'h39);
        @(negedge clk);
        chk("prio", 32'h1A, 32'({po, pc0, pc1}));
        apb(1'h1, cct_pkg::OFS_CTRL, 32'h8);
        cdiff(32'h0);
        tick <= 1'h1;
        cdiff(32'h3);
        apb(1'h1, cct_pkg::OFS_CTRL, 32'h0);
        cdiff(32'h0);
        apb(1'h1, cct_pkg::OFS_ENABLE, 32'h7);
        apb(1'h1, cct_pkg::OFS_COUNTER, 32'hFFFE);
        apb(1'h1, cct_pkg::OFS_CTRL, 32'h38);
        repeat (2) @(negedge clk);
        chk("ovf early", 32'h0, 32'(ovf));
        @(negedge clk);
        chk("ovf", 32'h1, 32'(ovf));
        apb(1'h1, cct_pkg::OFS_ENABLE, 32'h6);
        @(negedge clk);
        chk("ovf masked", 32'h0, 32'(ovf));
        apb(1'h1, cct_pkg::OFS_CTRL, 32'h30);
        apb(1'h1, cct_pkg::OFS_REQUEST, 32'h0);
        apb(1'h1, cct_pkg::OFS_COUNTER, 32'h3C);
        apb(1'h1, cct_pkg::OFS_MATCH0, 32'h40);
        apb(1'h1, cct_pkg::OFS_RELOAD0, 32'h80);
        apb(1'h1, cct_pkg::OFS_CH0_CTL, 32'h2);
        apb(1'h1, cct_pkg::OFS_CTRL, 32'h8);
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end
        while (o0 !== 1'h1 && n < 20);
        chk("pin delay", 32'h7, 32'(n));
        chk("early req", 32'h0, 32'(r0));
        @(posedge clk);
        insn <= 1'h1;
        @(posedge clk);
        insn <= 1'h0;
        @(negedge clk);
        chk("req", 32'h1, 32'(r0));
        rdc(cct_pkg::OFS_CH0_CTL, "ctl0", 32'hF9);
        rdc(cct_pkg::OFS_MATCH0, "reload", 32'h80);
        chk("oe1", 32'h0, 32'(oe1_n));
        apb(1'h1, cct_pkg::OFS_CH1_CTL, 32'h1);
        @(negedge clk);
        chk("pin1", 32'h1, 32'(o1));
        tick <= 1'h0;
        apb(1'h1, cct_pkg::OFS_CTRL, 32'h38);
        apb(1'h1, cct_pkg::OFS_COUNTER, 32'h1234);
        chk("oe0", 32'h1, 32'(oe0_n));
        for (int c = 0; c < 8; c++)
        begin
            apb(1'h1, cct_pkg::OFS_EDGE, 32'(c[1:0]) << (c[2] ? 4 : 2));
            for (int v = 1; v >= 0; v--)
            begin
                apb(1'h1, cct_pkg::OFS_REQUEST, 32'h0);
                apb(1'h1, c[2] ? cct_pkg::OFS_MATCH1 : cct_pkg::OFS_MATCH0,
                    32'h0);
                if (c[2])
                    src1.drive(v[0]);
                else
                    src0.drive(v[0]);
                hit = c[1:0] == cct_pkg::EDGE_BOTH ||
                      c[1:0] == (v ? cct_pkg::EDGE_RISE : cct_pkg::EDGE_FALL);
                rdc(cct_pkg::OFS_REQUEST, "cap req",
                    32'(hit) << (c[2] + 1));
                chk("req line", 32'(hit), 32'(c[2] ? r1 : r0));
                rdc(c[2] ? cct_pkg::OFS_MATCH1 : cct_pkg::OFS_MATCH0,
                    "cap value", hit ? 32'h1234 : 32'h0);
            end
        end
        give_verdict();
    end
endmodule // cct_timer_tb
`default_nettype wire
